/* File: logic/nibex_defines.svh */
// Constants for the nibble I/O expander link
// Operation
// - Four 4-bit ports, addressed zero to three
// - One shared 4-bit bidirectional nibble bus
// - Each transfer: command nibble then data
// - Command holds opcode and port; data follows
// - Bits 1:0 port, bits 3:2 operation
// - Power-up: ports floating, bus input
// - Leave power-on only after strobe falls
// - Falling strobe captures opcode and port
// - Read floats port, enables its input
// - Read data driven before rising strobe
// - Rising strobe ends read, releases bus
// - Write data taken at rising strobe
// - Write replaces latched port value
// - OR merges data into latched value
// - AND masks latched value with data
// - After write-type, port drives latched value
// - Latched value holds until next write-type
// - Chip select high freezes all state
// - Host discards first read after write
// - Host generates strobe framing every transfer
// - Separate chip selects for shared bus
`ifndef NIBEX_DEFINES_SVH
`define NIBEX_DEFINES_SVH
`define NIBEX_NIB_W 4
`define NIBEX_PORT_CNT 4
`define NIBEX_CMD_PORT_LSB 0
`define NIBEX_CMD_OP_LSB 2
`define NIBEX_OP_READ 2'h0
`define NIBEX_OP_WRITE 2'h1
`define NIBEX_OP_OR 2'h2
`define NIBEX_OP_AND 2'h3
`define NIBEX_LATCH_RESET 4'h0
`define NIBEX_STROBE_HALF_NS 800
`define NIBEX_CLK_NS 5
`define NIBEX_STROBE_HALF_CYC ((`NIBEX_STROBE_HALF_NS + `NIBEX_CLK_NS - 1) / `NIBEX_CLK_NS)
`endif

/* File: logic/nibex_pkg.sv */
// Types shared by both ends of the nibble expander link
package nibex_pkg;
  typedef logic [1:0] nibex_op_t;
  typedef logic [1:0] nibex_port_t;
  typedef logic [3:0] nibex_nib_t;
endpackage

/* File: logic/nibex_link_if.sv */
// Pin-level link between host and expander
`timescale 1ns/10ps
interface nibex_link_if;
  logic strobe_clock;
  logic chip_select_n;
  logic [3:0] bus_host_out;
  logic [3:0] bus_host_oe;
  logic [3:0] bus_dev_out;
  logic [3:0] bus_dev_oe;
  logic [3:0] host_nibble_bus;
  // Wired resolution of the shared nibble bus
  assign host_nibble_bus = (bus_host_out & bus_host_oe) | (bus_dev_out & bus_dev_oe);
  modport device (
    input strobe_clock,
    input chip_select_n,
    input host_nibble_bus,
    output bus_dev_out,
    output bus_dev_oe
  );
  modport host (
    output strobe_clock,
    output chip_select_n,
    input host_nibble_bus,
    output bus_host_out,
    output bus_host_oe
  );
endinterface

/* File: logic/nibex_device.sv */
// Expander end: four latched nibble ports driven from the strobe protocol
`timescale 1ns/10ps
`include "nibex_defines.svh"
module nibex_device
  import nibex_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  nibex_link_if.device link,
  input wire logic [15:0] port_pins_in,
  output logic [15:0] port_data_out,
  output logic [15:0] port_oe_out,
  output logic [15:0] port_in_en_out
);
  logic strobe_s1_reg, strobe_s2_reg, strobe_d_reg;
  logic cs_s1_reg, cs_s2_reg;
  logic [3:0] bus_s1_reg, bus_s2_reg;
  logic armed_reg;
  logic cmd_valid_reg;
  nibex_op_t op_reg;
  nibex_port_t port_reg;
  logic [15:0] latch_reg;
  logic [15:0] drive_reg;
  logic read_active_reg;
  logic [3:0] bus_out_reg;
  logic [3:0] bus_oe_reg;
  // Two-stage synchronisers on all link inputs
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      bus_s1_reg <= 4'h0;
      bus_s2_reg <= 4'h0;
    end else begin
      strobe_s1_reg <= link.strobe_clock;
      strobe_s2_reg <= strobe_s1_reg;
      strobe_d_reg <= strobe_s2_reg;
      cs_s1_reg <= link.chip_select_n;
      cs_s2_reg <= cs_s1_reg;
      bus_s1_reg <= link.host_nibble_bus;
      bus_s2_reg <= bus_s1_reg;
    end
  end
  // Edge detect gated by chip select; deselected edges are invisible
  wire selected = !cs_s2_reg;
  wire fall_seen = strobe_d_reg & !strobe_s2_reg;
  wire rise_seen = !strobe_d_reg & strobe_s2_reg;
  // Power-up strobe level is unknown, so the first fall only arms
  wire fall_ev = fall_seen & selected;
  wire rise_ev = rise_seen & selected & cmd_valid_reg & armed_reg;
  // Command decode from the synchronised bus
  wire nibex_op_t cmd_op = bus_s2_reg[`NIBEX_CMD_OP_LSB +: 2];
  wire nibex_port_t cmd_port = bus_s2_reg[`NIBEX_CMD_PORT_LSB +: 2];
  wire [3:0] cur_latch = latch_reg[port_reg*4 +: 4];
  // Result of a write-type transfer
  logic [3:0] merge_val;
  always_comb begin
    unique case (op_reg)
      `NIBEX_OP_OR: merge_val = cur_latch | bus_s2_reg;
      `NIBEX_OP_AND: merge_val = cur_latch & bus_s2_reg;
      default: merge_val = bus_s2_reg;
    endcase
  end
  // Command capture on the falling strobe
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      op_reg <= `NIBEX_OP_READ;
      port_reg <= 2'h0;
    end else if (fall_ev) begin
      armed_reg <= 1'b1;
      cmd_valid_reg <= armed_reg; // Arming fall carries no command
      op_reg <= cmd_op;
      port_reg <= cmd_port;
    end else if (rise_ev) begin
      cmd_valid_reg <= 1'b0;
    end
  end
  // Port latches change only on a write-type rising strobe
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_reg <= {4{`NIBEX_LATCH_RESET}};
      drive_reg <= 16'h0000;
    end else if (rise_ev && op_reg != `NIBEX_OP_READ) begin
      latch_reg[port_reg*4 +: 4] <= merge_val;
      drive_reg[port_reg*4 +: 4] <= 4'hf;
    end else if (fall_ev && armed_reg && cmd_op == `NIBEX_OP_READ) begin
      drive_reg[cmd_port*4 +: 4] <= 4'h0;
    end
  end
  // Read: bus driven from the addressed pins until the rising strobe
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_active_reg <= 1'b0;
      bus_out_reg <= 4'h0;
      bus_oe_reg <= 4'h0;
    end else if (rise_ev) begin
      read_active_reg <= 1'b0;
      bus_oe_reg <= 4'h0;
    end else if (fall_ev && armed_reg && cmd_op == `NIBEX_OP_READ) begin
      read_active_reg <= 1'b1;
      bus_oe_reg <= 4'hf;
    end else if (read_active_reg) begin
      bus_out_reg <= port_pins_in[port_reg*4 +: 4];
    end
  end
  // Input buffers enabled only on the port being read
  logic [15:0] in_en_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_en_reg <= 16'h0000;
    end else if (rise_ev) begin
      in_en_reg <= 16'h0000;
    end else if (fall_ev && armed_reg && cmd_op == `NIBEX_OP_READ) begin
      in_en_reg <= 16'h000f << (cmd_port * 4);
    end
  end
  assign port_data_out = latch_reg;
  assign port_oe_out = drive_reg;
  assign port_in_en_out = in_en_reg;
  assign link.bus_dev_out = bus_out_reg;
  assign link.bus_dev_oe = bus_oe_reg;
endmodule // nibex_device

/* File: logic/nibex_host.sv */
// Host end: issues two-nibble transfers with a divided strobe
`timescale 1ns/10ps
`include "nibex_defines.svh"
module nibex_host
  import nibex_pkg::*;
#(
  parameter int HALF_CYC = `NIBEX_STROBE_HALF_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  nibex_link_if.host link,
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic [1:0] req_port_in,
  input wire logic [3:0] req_data_in,
  input wire logic req_cs_n_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [3:0] rsp_data_out
);
  typedef enum logic [3:0] {
    NIBEX_IDLE = 4'h1, NIBEX_CMD = 4'h2, NIBEX_LOW = 4'h4, NIBEX_HIGH = 4'h8
  } nibex_state_e;
  nibex_state_e state_reg;
  logic [15:0] cnt_reg;
  logic strobe_reg, cs_n_reg, rsp_v_reg, ready_reg;
  logic [3:0] out_reg, oe_reg, rsp_reg;
  nibex_op_t op_reg;
  logic [3:0] data_reg;
  wire tick = (cnt_reg == 16'(HALF_CYC - 1));
  // Strobe sequencing: command, fall, data, rise
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= NIBEX_IDLE;
      cnt_reg <= 16'h0000;
      strobe_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
      op_reg <= 2'h0;
      data_reg <= 4'h0;
      rsp_reg <= 4'h0;
      rsp_v_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      rsp_v_reg <= 1'b0;
      cnt_reg <= (state_reg == NIBEX_IDLE || tick) ? 16'h0000 : cnt_reg + 16'h0001;
      unique case (state_reg)
        NIBEX_IDLE: if (req_valid_in) begin
          state_reg <= NIBEX_CMD;
          ready_reg <= 1'b0;
          cs_n_reg <= req_cs_n_in;
          out_reg <= {req_op_in, req_port_in};
          oe_reg <= 4'hf;
          op_reg <= req_op_in;
          data_reg <= req_data_in;
        end
        NIBEX_CMD: if (tick) begin
          state_reg <= NIBEX_LOW;
          strobe_reg <= 1'b0;
        end
        NIBEX_LOW: if (tick) begin
          state_reg <= NIBEX_HIGH;
          strobe_reg <= 1'b1;
          rsp_reg <= link.host_nibble_bus; // Sampled at rise
          rsp_v_reg <= (op_reg == `NIBEX_OP_READ); // caller discards post-write read
        end else if (cnt_reg == 16'h0001) begin
          out_reg <= data_reg;
          oe_reg <= (op_reg == `NIBEX_OP_READ) ? 4'h0 : 4'hf;
        end
        NIBEX_HIGH: if (tick) begin
          state_reg <= NIBEX_IDLE;
          oe_reg <= 4'h0;
          cs_n_reg <= 1'b1;
          ready_reg <= 1'b1;
        end
      endcase
    end
  end
  assign link.strobe_clock = strobe_reg;
  assign link.chip_select_n = cs_n_reg;
  assign link.bus_host_out = out_reg;
  assign link.bus_host_oe = oe_reg;
  assign req_ready_out = ready_reg;
  assign rsp_valid_out = rsp_v_reg;
  assign rsp_data_out = rsp_reg;
endmodule // nibex_host

/* File: dv/nibex_chk.sv */
// Link assertions for the nibble expander pair
`timescale 1ns/10ps
module nibex_chk (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic strobe_clock,
  input wire logic chip_select_n,
  input wire logic [3:0] host_nibble_bus,
  input wire logic [3:0] bus_host_oe,
  input wire logic [3:0] bus_dev_oe,
  input wire logic [15:0] port_pins_in,
  input wire logic [15:0] port_data_out,
  input wire logic [15:0] port_oe_out,
  input wire logic [15:0] port_in_en_out
);
  logic strb_reg;
  logic [1:0] falls_reg;
  logic [3:0] cmd_reg;
  logic [3:0] age_reg;
  // Selected strobe edges; the first selected fall only arms the device
  wire fall = strb_reg & ~strobe_clock & ~chip_select_n;
  wire rise = ~strb_reg & strobe_clock & ~chip_select_n;
  wire on_w = falls_reg == 2'h2;
  wire [3:0] old_w = port_data_out[{cmd_reg[1:0], 2'h0} +: 4];
  wire [3:0] new_w = cmd_reg[3:2] == 2'h1 ? host_nibble_bus :
    cmd_reg[3:2] == 2'h2 ? (old_w | host_nibble_bus) : (old_w & host_nibble_bus);
  // Edge tracker; saturating fall count avoids wrap back to unarmed
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strb_reg <= 1'b1;
      falls_reg <= 2'h0;
      cmd_reg <= 4'h0;
      age_reg <= 4'hf;
    end else begin
      strb_reg <= strobe_clock;
      if (fall && !on_w) falls_reg <= falls_reg + 2'h1;
      if (fall) cmd_reg <= host_nibble_bus;
      age_reg <= rise ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Wire relations
  property p_clash; (bus_host_oe & bus_dev_oe) == 4'h0; endproperty
  a_clash: assert property (p_clash) else $error("bus driven by both ends");
  property p_freeze; chip_select_n [*4] |=> $stable(port_data_out) && $stable(port_oe_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("deselected state changed");
  property p_idle; falls_reg != 2'h2 |-> port_oe_out == 16'h0 && bus_dev_oe == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("drive before arming");
  property p_float;
    fall && host_nibble_bus[3:2] == 2'h0 && falls_reg != 2'h0 |-> ##[1:8]
      (port_oe_out[{cmd_reg[1:0], 2'h0} +: 4] == 4'h0 &&
       port_in_en_out[{cmd_reg[1:0], 2'h0} +: 4] == 4'hf);
  endproperty
  a_float: assert property (p_float) else $error("read port not floated");
  property p_drive;
    rise && bus_host_oe == 4'h0 && on_w |-> bus_dev_oe == 4'hf &&
      host_nibble_bus == port_pins_in[{cmd_reg[1:0], 2'h0} +: 4];
  endproperty
  a_drive: assert property (p_drive) else $error("read data missing");
  property p_end; rise |-> ##8 bus_dev_oe == 4'h0; endproperty
  a_end: assert property (p_end) else $error("bus kept after read");
  property p_write;
    rise && cmd_reg[3:2] != 2'h0 && on_w |-> ##8 port_oe_out[{cmd_reg[1:0], 2'h0} +: 4] == 4'hf
      && port_data_out[{cmd_reg[1:0], 2'h0} +: 4] == $past(new_w, 8);
  endproperty
  a_write: assert property (p_write) else $error("bad latch");
  property p_hold; $changed(port_data_out) |-> age_reg < 4'h8; endproperty
  a_hold: assert property (p_hold) else $error("latch moved unasked");
  c_read: cover property (rise && on_w && cmd_reg[3:2] == 2'h0);
  c_write: cover property (rise && on_w && cmd_reg[3:2] == 2'h3);
  c_desel: cover property (chip_select_n && strb_reg && !strobe_clock);
endmodule // nibex_chk

/* File: dv/tb.sv */
// Host and expander back to back, driven from the host request side
`timescale 1ns/10ps
module tb;
  logic clock_in, rst_n_in, req_valid_in, req_cs_n_in, req_ready_out, rsp_valid_out;
  logic [1:0] req_op_in, req_port_in;
  logic [3:0] req_data_in, rsp_data_out, rd_v, fresh;
  logic [15:0] port_pins_in, port_data_out, port_oe_out, port_in_en_out, exp_d, exp_oe;
  int n_fail, checks_done, p;
  nibex_link_if link();
  // Short strobe half period keeps the run brief
  nibex_host #(.HALF_CYC(8)) i_nibex_host (.clock_in, .rst_n_in, .link(link), .req_valid_in,
    .req_op_in, .req_port_in, .req_data_in, .req_cs_n_in, .req_ready_out, .rsp_valid_out,
    .rsp_data_out);
  nibex_device i_nibex_device (.clock_in, .rst_n_in, .link(link), .port_pins_in,
    .port_data_out, .port_oe_out, .port_in_en_out);
  nibex_chk i_nibex_chk (.clock_in, .rst_n_in, .strobe_clock(link.strobe_clock),
    .chip_select_n(link.chip_select_n), .host_nibble_bus(link.host_nibble_bus),
    .bus_host_oe(link.bus_host_oe), .bus_dev_oe(link.bus_dev_oe), .port_pins_in,
    .port_data_out, .port_oe_out, .port_in_en_out);
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic close_out();
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One whole transfer; command nibble watched on the wire at the strobe fall
  task automatic xfer(input logic [1:0] o, input logic [1:0] pt, input logic [3:0] d,
    input logic cs);
    int i;
    bit seen;
    seen = 0;
    @(negedge clock_in);
    {req_valid_in, req_op_in, req_port_in, req_data_in, req_cs_n_in} = {1'b1, o, pt, d, cs};
    @(negedge clock_in);
    req_valid_in = 1'b0;
    for (i = 0; i < 80; i++) begin
      @(negedge clock_in);
      if (link.strobe_clock === 1'b0 && !seen) begin
        seen = 1;
        check({12'h0, link.host_nibble_bus}, {12'h0, o, pt});
      end
      if (rsp_valid_out === 1'b1) rd_v = rsp_data_out;
      if (req_ready_out === 1'b1) break;
    end
    if (i == 80) begin
      n_fail++;
      close_out();
    end
  endtask
  // Transfer plus expected latch, drive and read-back
  task automatic op(input logic [1:0] o, input logic [1:0] pt, input logic [3:0] d,
    input logic cs);
    logic [3:0] n;
    n = exp_d[{pt, 2'h0} +: 4];
    xfer(o, pt, d, cs);
    if (!cs && o == 2'h1) n = d;
    if (!cs && o == 2'h2) n = n | d;
    if (!cs && o == 2'h3) n = n & d;
    exp_d[{pt, 2'h0} +: 4] = n;
    if (!cs) exp_oe[{pt, 2'h0} +: 4] = {4{o != 2'h0}};
    // First read after a write is junk by protocol
    if (!cs && o == 2'h0 && !fresh[pt])
      check({12'h0, rd_v}, {12'h0, port_pins_in[{pt, 2'h0} +: 4]});
    if (!cs) fresh[pt] = o != 2'h0;
    check(port_data_out, exp_d);
    check(port_oe_out, exp_oe);
  endtask
  // Main sequence
  initial begin
    {n_fail, checks_done, req_valid_in, req_op_in, req_port_in, req_data_in} = 0;
    {req_cs_n_in, rst_n_in, port_pins_in, exp_d, exp_oe, fresh} = {2'b10, 16'h9c53, 36'h0};
    repeat (20) @(negedge clock_in);
    rst_n_in = 1'b1;
    check(port_oe_out, 16'h0);
    xfer(2'h1, 2'h0, 4'hf, 1'b0);
    check(port_oe_out, 16'h0);
    check(port_data_out, 16'h0);
    for (p = 0; p < 4; p++) op(2'h0, p[1:0], 4'h0, 1'b0);
    for (p = 0; p < 4; p++) begin
      op(2'h1, p[1:0], 4'h6 ^ p[3:0], 1'b0);
      op(2'h2, p[1:0], 4'h9, 1'b0);
      op(2'h3, p[1:0], 4'h5, 1'b0);
    end
    op(2'h1, 2'h2, 4'h0, 1'b1);
    op(2'h0, 2'h1, 4'h0, 1'b0);
    op(2'h0, 2'h1, 4'h0, 1'b0);
    // Reset in mid-run must restore the power-on state
    rst_n_in = 1'b0;
    @(negedge clock_in);
    check(port_data_out | port_oe_out, 16'h0);
    {rst_n_in, exp_d, exp_oe, fresh} = {1'b1, 36'h0};
    xfer(2'h0, 2'h3, 4'h0, 1'b0);
    op(2'h0, 2'h3, 4'h0, 1'b0);
    close_out();
  end
endmodule // tb
